//--- logic/pwmo_pkg.sv
// constants shared by the modulator output control block
// Overview of operation
// - control bit 7 runs the modulator when set, disables it when clear
// - control bit 6 passes modulator output to its pin, else blocks it
// - control bit 5 reads the live modulator output; writes ignored
// - control bit 4 set makes the modulator output active-low
// - several enabled outputs on one pin: highest priority one wins
// - digital outputs still drive a pin selected as analog input
// - modulator ranks above port latch, below every other pin function
// - direction bit one disables pin driver, zero enables it
package pwmo_pkg;
  localparam int unsigned APB_AW = 8;
  // register byte offsets
  localparam logic [APB_AW-1:0] OFS_CONTROL  = 8'h00;
  localparam logic [APB_AW-1:0] OFS_DUTY_HI  = 8'h04;
  localparam logic [APB_AW-1:0] OFS_DUTY_LO  = 8'h08;
  localparam logic [APB_AW-1:0] OFS_PERIOD   = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_TMR_CTRL = 8'h10;
  localparam logic [APB_AW-1:0] OFS_INT_STAT = 8'h14;
  localparam logic [APB_AW-1:0] OFS_INT_MASK = 8'h18;
  localparam logic [APB_AW-1:0] OFS_PIN_DIR  = 8'h1C;
  localparam logic [APB_AW-1:0] OFS_PORT_LAT = 8'h20;
  localparam logic [APB_AW-1:0] OFS_ANALOG   = 8'h24;
  localparam logic [APB_AW-1:0] OFS_PORT_IN  = 8'h28;
  // control register fields
  localparam int unsigned CTL_EN_BIT  = 7;
  localparam int unsigned CTL_OE_BIT  = 6;
  localparam int unsigned CTL_OUT_BIT = 5;
  localparam int unsigned CTL_POL_BIT = 4;
  localparam int unsigned CTL_LOW_MSB = 3;
  localparam logic [7:0]  CTL_WR_MASK = 8'hD0;
  // duty low register keeps bits 7:6
  localparam int unsigned DUTY_LO_MSB = 7;
  localparam int unsigned DUTY_LO_LSB = 6;
  // timer control fields
  localparam int unsigned TMR_RUN_BIT = 2;
  localparam int unsigned TMR_PS_MSB  = 1;
  // interrupt status bits
  localparam int unsigned IRQ_NUM     = 2;
  localparam int unsigned IRQ_OVF_BIT = 0;
  localparam int unsigned IRQ_DUTY_BIT = 1;
  // reset values
  localparam logic [7:0]  RST_CONTROL = 8'h00;
  localparam logic [7:0]  RST_PERIOD  = 8'hFF;
  localparam logic        RST_DIR     = 1'b1;
  localparam logic        RST_ANALOG  = 1'b1;
  // prescale limits for selections 1:1, 1:4, 1:16, 1:64
  localparam int unsigned PS_W = 6;
  localparam logic [PS_W-1:0] PS_LIM_1  = 6'h00;
  localparam logic [PS_W-1:0] PS_LIM_4  = 6'h03;
  localparam logic [PS_W-1:0] PS_LIM_16 = 6'h0F;
  localparam logic [PS_W-1:0] PS_LIM_64 = 6'h3F;
  localparam logic [1:0]      PS_SEL_1  = 2'h0;
  localparam logic [1:0]      PS_SEL_4  = 2'h1;
  localparam logic [1:0]      PS_SEL_16 = 2'h2;
endpackage

//--- logic/pwmo_pin_mux.sv
// fixed output priority multiplexer for one port pin
`timescale 1ns/10ps
module pwmo_pin_mux #(
  parameter int unsigned NUM_HI = 4
) (
  input  wire logic [NUM_HI-1:0] hiEn,
  input  wire logic [NUM_HI-1:0] hiVal,
  input  wire logic              pwmEn,
  input  wire logic              pwmVal,
  input  wire logic              latchVal,
  input  wire logic              dirInput,
  output logic                   pinVal,
  output logic                   pinDrive
);
  // walk from lowest to highest priority so the highest enabled function wins
  always_comb begin
    pinVal = latchVal;
    if (pwmEn) begin
      pinVal = pwmVal;
    end
    for (int i = NUM_HI - 1; i >= 0; i--) begin
      if (hiEn[i]) begin
        pinVal = hiVal[i];
      end
    end
  end

  // analog input selection takes no part here, so outputs still reach the pin
  assign pinDrive = ~dirInput;
endmodule

//--- logic/pwmo_output_control.sv
// modulator with control register, period timer, interrupts and pin output path
`timescale 1ns/10ps
module pwmo_output_control
  import pwmo_pkg::*;
#(
  parameter int unsigned NUM_HI = 4
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NUM_HI-1:0] hiFuncEn,
  input  wire logic [NUM_HI-1:0] hiFuncVal,
  input  wire logic              pinIn,
  output logic                   pinOut,
  output logic                   pinOe,
  output logic                   pwmLive,
  output logic                   irq
);
  // register state
  logic              enQ;
  logic              oeQ;
  logic              polQ;
  logic [7:0]        dutyHiQ;
  logic [1:0]        dutyLoQ;
  logic [7:0]        periodQ;
  logic              runQ;
  logic [1:0]        psSelQ;
  logic [IRQ_NUM-1:0] statQ;
  logic [IRQ_NUM-1:0] maskQ;
  logic              dirQ;
  logic              latQ;
  logic              anaQ;
  // timer and modulator state
  logic [PS_W-1:0]   preCntQ;
  logic [7:0]        cntQ;
  logic [9:0]        dutyActQ;
  logic              pwmOutQ;
  logic              rawPrevQ;
  // bus answer, pin output and interrupt output state
  logic              preadyQ;
  logic [31:0]       prdataQ;
  logic              pslverrQ;
  logic              pinOutQ;
  logic              pinOeQ;
  logic              irqQ;

  // bus decode
  logic        accessPhase;
  logic        xferDone;
  logic        wrEn;
  logic        selCtrl;
  logic        selDutyHi;
  logic        selDutyLo;
  logic        selPeriod;
  logic        selTmr;
  logic        selStat;
  logic        selMask;
  logic        selDir;
  logic        selLat;
  logic        selAna;
  logic        selPortIn;
  logic        mapped;
  logic [31:0] rdMux;
  logic [7:0]  ctrlRead;

  assign accessPhase = psel & penable;
  assign xferDone    = accessPhase & preadyQ;
  assign wrEn        = xferDone & pwrite;
  assign selCtrl     = (paddr == OFS_CONTROL);
  assign selDutyHi   = (paddr == OFS_DUTY_HI);
  assign selDutyLo   = (paddr == OFS_DUTY_LO);
  assign selPeriod   = (paddr == OFS_PERIOD);
  assign selTmr      = (paddr == OFS_TMR_CTRL);
  assign selStat     = (paddr == OFS_INT_STAT);
  assign selMask     = (paddr == OFS_INT_MASK);
  assign selDir      = (paddr == OFS_PIN_DIR);
  assign selLat      = (paddr == OFS_PORT_LAT);
  assign selAna      = (paddr == OFS_ANALOG);
  assign selPortIn   = (paddr == OFS_PORT_IN);
  assign mapped      = selCtrl | selDutyHi | selDutyLo | selPeriod | selTmr | selStat |
                       selMask | selDir | selLat | selAna | selPortIn;

  // live output bit shows the flop, low nibble reads zero
  assign ctrlRead = {enQ, oeQ, pwmOutQ, polQ, 4'h0};

  logic portInView;
  assign portInView = pinIn & ~anaQ;

  assign rdMux = selCtrl   ? {24'h000000, ctrlRead} :
                 selDutyHi ? {24'h000000, dutyHiQ} :
                 selDutyLo ? {24'h000000, dutyLoQ, 6'h00} :
                 selPeriod ? {24'h000000, periodQ} :
                 selTmr    ? {29'h00000000, runQ, psSelQ} :
                 selStat   ? {30'h00000000, statQ} :
                 selMask   ? {30'h00000000, maskQ} :
                 selDir    ? {31'h00000000, dirQ} :
                 selLat    ? {31'h00000000, latQ} :
                 selAna    ? {31'h00000000, anaQ} :
                 selPortIn ? {31'h00000000, portInView} :
                             32'h00000000;

  // one wait state: pready rises in the first access cycle's following edge
  logic preadyD;
  assign preadyD = accessPhase & ~preadyQ;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      preadyQ  <= 1'b0;
      prdataQ  <= 32'h00000000;
      pslverrQ <= 1'b0;
    end else if (ce) begin
      preadyQ  <= preadyD;
      pslverrQ <= preadyD & ~mapped;
      if (preadyD && !pwrite) begin
        prdataQ <= rdMux;
      end
    end
  end

  // control register: only bits 7, 6 and 4 are storage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      enQ  <= RST_CONTROL[CTL_EN_BIT];
      oeQ  <= RST_CONTROL[CTL_OE_BIT];
      polQ <= RST_CONTROL[CTL_POL_BIT];
    end else if (ce && wrEn && selCtrl) begin
      enQ  <= pwdata[CTL_EN_BIT];
      oeQ  <= pwdata[CTL_OE_BIT];
      polQ <= pwdata[CTL_POL_BIT];
    end
  end

  // duty, period, timer control and port registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dutyHiQ <= 8'h00;
      dutyLoQ <= 2'h0;
      periodQ <= RST_PERIOD;
      runQ    <= 1'b0;
      psSelQ  <= 2'h0;
      maskQ   <= '0;
      dirQ    <= RST_DIR;
      latQ    <= 1'b0;
      anaQ    <= RST_ANALOG;
    end else if (ce && wrEn) begin
      if (selDutyHi) dutyHiQ <= pwdata[7:0];
      if (selDutyLo) dutyLoQ <= pwdata[DUTY_LO_MSB:DUTY_LO_LSB];
      if (selPeriod) periodQ <= pwdata[7:0];
      if (selTmr) begin
        runQ   <= pwdata[TMR_RUN_BIT];
        psSelQ <= pwdata[TMR_PS_MSB:0];
      end
      if (selMask) maskQ <= pwdata[IRQ_NUM-1:0];
      if (selDir)  dirQ  <= pwdata[0];
      if (selLat)  latQ  <= pwdata[0];
      if (selAna)  anaQ  <= pwdata[0];
    end
  end

  // period timer
  logic [PS_W-1:0] psLimit;
  logic            tick;
  logic            periodEnd;
  logic [9:0]      fineCnt;
  logic [9:0]      dutyReq;

  assign psLimit   = (psSelQ == PS_SEL_1)  ? PS_LIM_1 :
                     (psSelQ == PS_SEL_4)  ? PS_LIM_4 :
                     (psSelQ == PS_SEL_16) ? PS_LIM_16 : PS_LIM_64;
  assign tick      = runQ & (preCntQ >= psLimit);
  assign periodEnd = tick & (cntQ == periodQ);
  assign fineCnt   = {cntQ, preCntQ[1:0]};
  assign dutyReq   = {dutyHiQ, dutyLoQ};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      preCntQ <= '0;
      cntQ    <= 8'h00;
    end else if (ce) begin
      if (!runQ || tick) begin
        preCntQ <= '0;
      end else begin
        preCntQ <= preCntQ + 1'b1;
      end
      if (periodEnd) begin
        cntQ <= 8'h00;
      end else if (tick) begin
        cntQ <= cntQ + 8'h01;
      end
    end
  end

  // duty is taken at each period start so a period never sees a torn value
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dutyActQ <= 10'h000;
    end else if (ce && (periodEnd || !runQ)) begin
      dutyActQ <= dutyReq;
    end
  end

  // modulator output: active from period start until count reaches duty
  logic pwmRaw;
  logic pwmLiveD;
  assign pwmRaw   = enQ & (fineCnt < dutyActQ);
  assign pwmLiveD = enQ ? (pwmRaw ^ polQ) : 1'b0;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pwmOutQ  <= 1'b0;
      rawPrevQ <= 1'b0;
    end else if (ce) begin
      pwmOutQ  <= pwmLiveD;
      rawPrevQ <= pwmRaw;
    end
  end

  // sticky events, write one to clear, a new event beats the clear
  logic [IRQ_NUM-1:0] evt;
  logic [IRQ_NUM-1:0] clr;
  assign evt[IRQ_OVF_BIT]  = periodEnd;
  assign evt[IRQ_DUTY_BIT] = rawPrevQ & ~pwmRaw;
  assign clr = (wrEn && selStat) ? pwdata[IRQ_NUM-1:0] : '0;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      statQ <= '0;
      irqQ  <= 1'b0;
    end else if (ce) begin
      statQ <= (statQ & ~clr) | evt;
      irqQ  <= |(((statQ & ~clr) | evt) & maskQ);
    end
  end

  // pin path through fixed priority
  logic muxVal;
  logic muxDrive;
  pwmo_pin_mux #(
    .NUM_HI (NUM_HI)
  ) u_pin_mux (
    .hiEn     (hiFuncEn),
    .hiVal    (hiFuncVal),
    .pwmEn    (oeQ),
    .pwmVal   (pwmOutQ),
    .latchVal (latQ),
    .dirInput (dirQ),
    .pinVal   (muxVal),
    .pinDrive (muxDrive)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pinOutQ <= 1'b0;
      pinOeQ  <= 1'b0;
    end else if (ce) begin
      pinOutQ <= muxVal;
      pinOeQ  <= muxDrive;
    end
  end

  assign prdata  = prdataQ;
  assign pready  = preadyQ;
  assign pslverr = pslverrQ;
  assign pinOut  = pinOutQ;
  assign pinOe   = pinOeQ;
  assign pwmLive = pwmOutQ;
  assign irq     = irqQ;

  // checks
  ctrlLowZero_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && preadyD && !pwrite && selCtrl) |=> (prdata[CTL_LOW_MSB:0] == 4'h0))
    else $error("control low bits not zero");

  liveRead_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && preadyD && !pwrite && selCtrl) |=> (prdata[CTL_OUT_BIT] == $past(pwmOutQ)))
    else $error("live output bit does not follow modulator");

  liveOff_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && !enQ) |=> !pwmOutQ)
    else $error("disabled modulator output not low");

  polarity_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && enQ) |=> (pwmOutQ == ($past(pwmRaw) ^ $past(polQ))))
    else $error("polarity not applied");

  dutyShape_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && enQ && periodEnd && (dutyReq == 10'h000)) |=> (ce |-> ##1 (pwmOutQ == $past(polQ))))
    else $error("zero duty still pulsed");

  pinBlock_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && !oeQ && (hiFuncEn == '0)) |=> (pinOut == $past(latQ)))
    else $error("blocked modulator reached pin");

  pwmRank_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && oeQ && (hiFuncEn == '0)) |=> (pinOut == $past(pwmOutQ)))
    else $error("modulator did not beat port latch");

  topPrio_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && hiFuncEn[0]) |=> (pinOut == $past(hiFuncVal[0])))
    else $error("highest priority function lost the pin");

  dirOff_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && dirQ) |=> !pinOe)
    else $error("input direction still drives pin");

  analogDrive_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && !dirQ && anaQ) |=> pinOe)
    else $error("analog selection blocked output driver");

  enWrite_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && wrEn && selCtrl) |=> (enQ == $past(pwdata[CTL_EN_BIT])))
    else $error("enable bit not written");

  oeWrite_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && wrEn && selCtrl) |=> (oeQ == $past(pwdata[CTL_OE_BIT])))
    else $error("pin output enable bit not written");

  polWrite_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && wrEn && selCtrl) |=> (polQ == $past(pwdata[CTL_POL_BIT])))
    else $error("polarity bit not written");

  dutyHigh_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && enQ && !polQ && (fineCnt < dutyActQ)) |=> pwmOutQ)
    else $error("output low before duty reached");

  dutyLow_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && enQ && !polQ && (fineCnt >= dutyActQ)) |=> !pwmOutQ)
    else $error("output high after duty reached");

  dirOn_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && !dirQ) |=> pinOe)
    else $error("output direction did not drive pin");

  readyPulse_a: assert property (@(posedge clock) disable iff (!rstn)
    (ce && pready) |=> !pready)
    else $error("ready held longer than one cycle");
endmodule

//--- testbench/pwmo_pin_model.sv
// port pin with pull-up, resolved from the block's driver
`timescale 1ns/10ps
module pwmo_pin_model (
  input  wire logic pinOut,
  input  wire logic pinOe,
  output logic      pinIn
);
  // released pin floats to the pull-up level
  assign pinIn = pinOe ? pinOut : 1'b1;
endmodule

//--- testbench/test_pwm_output_control.sv
// self-checking bench for the modulator output control block
`timescale 1ns/10ps
module test_pwm_output_control;
  import pwmo_pkg::*;
  logic        clock = 0;
  logic        rstn = 0;
  logic        ce = 1'b1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  hiFuncEn = 4'h0;
  logic [3:0]  hiFuncVal = 4'h0;
  logic        pinIn;
  logic        pinOut;
  logic        pinOe;
  logic        pwmLive;
  logic        irq;
  logic        err;
  logic [31:0] rdv;
  int          failures = 0;
  int          totalChecks = 0;

  always #4 clock = ~clock;

  pwmo_output_control #(.NUM_HI(4)) uut (
    .clock(clock), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hiFuncEn(hiFuncEn),
    .hiFuncVal(hiFuncVal), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pwmLive(pwmLive), .irq(irq)
  );
  pwmo_pin_model pin (.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // the watchdog ends a wait that never sees pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // high cycles of live output and pin over 16 cycles, four whole periods
  task automatic highs(input int expN);
    logic [31:0] hL;
    logic [31:0] hP;
    hL = 32'h0;
    hP = 32'h0;
    repeat (16) begin
      @(posedge clock);
      hL += pwmLive;
      hP += pinOut;
    end
    chk(hL, expN);
    chk(hP, expN);
  endtask

  task automatic t_reset;
    apb(1'b0, OFS_CONTROL, 0);
    chk(rdv, 32'h0);
    chk({pinOe, irq, pwmLive}, 3'h0);
  endtask

  task automatic t_bringup;
    int n;
    wr(OFS_PIN_DIR, 1);
    wr(OFS_CONTROL, 0);
    wr(OFS_PERIOD, 3);
    wr(OFS_DUTY_HI, 0);
    wr(OFS_DUTY_LO, 0);
    wr(OFS_INT_STAT, 1);
    wr(OFS_TMR_CTRL, {30'h0, PS_SEL_1});
    wr(OFS_TMR_CTRL, 32'h4);
    wr(OFS_CONTROL, 32'h40);
    n = 0;
    do begin
      apb(1'b0, OFS_INT_STAT, 0);
      n++;
    end while (rdv[0] !== 1'b1 && n < 20);
    chk(rdv[0], 1'b1);
    wr(OFS_PIN_DIR, 0);
    wr(OFS_CONTROL, 32'hC0);
    waitc(2);
    chk(pinOe, 1'b1);
  endtask

  task automatic t_waveform;
    wr(OFS_DUTY_HI, 1);
    waitc(8);
    highs(4);
    wr(OFS_CONTROL, 32'hD0);
    waitc(2);
    highs(12);
    apb(1'b0, OFS_CONTROL, 0);
    chk(rdv & 32'hDF, 32'hD0);
    wr(OFS_CONTROL, 32'h6F);
    waitc(2);
    apb(1'b0, OFS_CONTROL, 0);
    chk(rdv, 32'h40);
    highs(0);
  endtask

  task automatic t_priority;
    logic [8:0] tab [5] = '{9'h000, 9'h020, 9'h0E4, 9'h16F, 9'h1F1};
    logic       liveHeld;
    wr(OFS_ANALOG, 1);
    wr(OFS_PORT_LAT, 1);
    wr(OFS_CONTROL, 32'h80);
    waitc(2);
    chk(pinOut, 1'b1);
    wr(OFS_CONTROL, 32'hD0);
    foreach (tab[i]) begin
      hiFuncEn <= tab[i][7:4];
      hiFuncVal <= tab[i][3:0];
      waitc(2);
      liveHeld = pwmLive;
      waitc(1);
      if (i == 0) chk(pinOut, liveHeld);
      else chk(pinOut, tab[i][8]);
    end
    hiFuncEn <= 4'h0;
  endtask

  // clock enable low holds the modulator and the pin path still
  task automatic t_freeze;
    logic liveHeld;
    logic pinHeld;
    ce <= 1'b0;
    waitc(1);
    liveHeld = pwmLive;
    pinHeld = pinOut;
    repeat (6) begin
      waitc(1);
      chk(pwmLive, liveHeld);
      chk(pinOut, pinHeld);
    end
    ce <= 1'b1;
  endtask

  task automatic t_irq;
    apb(1'b0, OFS_INT_STAT, 0);
    chk(rdv, 32'h3);
    wr(OFS_INT_MASK, 1);
    waitc(6);
    chk(irq, 1'b1);
    wr(OFS_INT_MASK, 0);
    waitc(2);
    chk(irq, 1'b0);
    wr(OFS_TMR_CTRL, 0);
    wr(OFS_INT_STAT, 3);
    apb(1'b0, OFS_INT_STAT, 0);
    chk(rdv, 32'h0);
  endtask

  task automatic t_misc;
    apb(1'b0, 8'h3C, 0);
    chk({31'h0, err}, 32'h1);
    chk(rdv, 32'h0);
    wr(OFS_PIN_DIR, 1);
    apb(1'b0, OFS_PORT_IN, 0);
    chk(rdv, 32'h0);
    wr(OFS_ANALOG, 0);
    apb(1'b0, OFS_PORT_IN, 0);
    chk(rdv, 32'h1);
  endtask

  task automatic end_sim;
    $display("checks=%0d failures=%0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_bringup();
    t_waveform();
    t_priority();
    t_freeze();
    t_irq();
    t_misc();
    end_sim();
  end

  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule
